// *** rtl/alarm_pkg.sv ***
// Shared types and constants for the link alarm monitor.
// Assumes a single 10 MHz clock and a word-wide register port.
package alarm_pkg;

  // Clock and timing
  localparam int CLK_PERIOD_NS = 100;
  localparam int MODE_GAP_NS = 2_000_000;
  localparam int MODE_GAP_CYCLES = (MODE_GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int GAP_W = 16;

  // Register offsets (byte addresses)
  localparam logic [7:0] OFS_CONFIG = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_MASK = 8'h08;
  localparam logic [7:0] OFS_STATE = 8'h0c;

  // Config fields
  localparam int CFG_LIMIT_LSB = 0;
  localparam int CFG_FULLSYNC_BIT = 8;
  localparam logic [7:0] LIMIT_RESET = 8'h00;

  // Status and mask bit positions
  localparam int ST_TALLY = 0;
  localparam int ST_SYNC = 1;
  localparam int ST_CMD = 2;
  localparam int ST_W = 3;

  // State register fields
  localparam int SR_LINK_BIT = 0;
  localparam int SR_SYNC_LSB = 1;
  localparam int SR_TALLY_LSB = 8;

  // Cyclic command and control mode codes
  localparam logic [2:0] CMD_HOMING = 3'h4;
  localparam logic [1:0] MODE_POSITION = 2'h0;
  localparam logic [1:0] MODE_VELOCITY = 2'h1;
  localparam logic [1:0] MODE_TORQUE = 2'h2;
  localparam logic [1:0] MODE_PROFILE = 2'h3;

  typedef enum logic [0:0] {LINK_INITIAL, LINK_ACTIVE} link_state_t;
  typedef enum logic [1:0] {SYNC_NONE, SYNC_TRANSIENT, SYNC_DONE} sync_state_t;

  // One received cyclic frame, as decoded by the frame receiver
  typedef struct packed {
    logic [2:0] cyc_cmd;
    logic [1:0] ctrl_mode;
    logic [7:0] type_code;
    logic [3:0] renew_cnt;
    logic busy;
    logic full_closed;
    logic frame32;
    logic [1:0] cycle_sel;
  } frame_t;

endpackage

// *** rtl/renewal_tally.sv ***
// Renewal counter tracker: counts wrong successors and flags overflow.
// Assumes check pulses only arrive while the check window is open.
`timescale 1ns/1ps
module renewal_tally
  import alarm_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Check control
  input wire logic restart,
  input wire logic check,
  input wire logic [3:0] renew_cnt,
  input wire logic [7:0] limit,
  // Results
  output logic [7:0] tally,
  output logic over
);
  logic have_prev;
  logic [3:0] prev_cnt;
  logic miss;

  // Host advances by one each renewal cycle
  assign miss = have_prev && (renew_cnt != 4'(prev_cnt + 4'h1));

  // Expected successor tracking
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      have_prev <= 1'b0;
      prev_cnt <= 4'h0;
    end
    else if (restart)
      have_prev <= 1'b0;
    else if (check)
    begin
      have_prev <= 1'b1;
      prev_cnt <= renew_cnt;
    end
  end

  // Saturating failure count
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      tally <= 8'h00;
    else if (restart)
      tally <= 8'h00;
    else if (check && miss && tally != 8'hff)
      tally <= tally + 8'h01;
  end

  // Limit 0 or 1 disables the alarm entirely
  assign over = (limit > 8'h01) && (tally > limit);
endmodule // renewal_tally

// *** rtl/mode_gap_timer.sv ***
// Time since the last control mode change, in clock cycles.
// Starts out as if the gap had long elapsed.
`timescale 1ns/1ps
module mode_gap_timer
  import alarm_pkg::*;
#(
  parameter int GAP_CYCLES = MODE_GAP_CYCLES
)
(
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Mode change event
  input wire logic mode_change,
  // Gap still link_active_state
  output logic too_soon
);
  logic [GAP_W-1:0] count;

  // Restart on each change, saturate at the gap length
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      count <= GAP_W'(GAP_CYCLES);
    else if (mode_change)
      count <= '0;
    else if (count < GAP_W'(GAP_CYCLES))
      count <= count + 1'b1;
  end

  assign too_soon = count < GAP_W'(GAP_CYCLES);
endmodule // mode_gap_timer

// *** rtl/link_alarm_monitor.sv ***
// Alarm detection for the cyclic command stream of a networked servo drive.
// Assumes decoded frames arrive with a one-cycle rx_valid strobe.
`timescale 1ns/1ps
module link_alarm_monitor
  import alarm_pkg::*;
#(
  parameter int GAP_CYCLES = alarm_pkg::MODE_GAP_CYCLES
)
(
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Received frames
  input wire logic rx_valid,
  input wire logic renew_tick,
  input wire alarm_pkg::frame_t rx_frame,
  // Link events
  input wire logic link_up,
  input wire logic comm_error,
  input wire logic comm_lost,
  input wire logic sync_start,
  input wire logic sync_done,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // Alarm and status outputs
  output logic renewal_tally_alarm,
  output logic interaxis_sync_alarm,
  output logic command_error_alarm,
  output logic frame_accept,
  output alarm_pkg::link_state_t link_state,
  output alarm_pkg::sync_state_t sync_state,
  output logic irq
);
  import alarm_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // Decoding helpers

  // Profile latch positioning or profile homing operations
  function automatic logic is_latch_home(input logic [7:0] tc);
    is_latch_home = (tc == 8'h12) || (tc == 8'h13) || (tc == 8'h31) ||
                    (tc == 8'h32) || (tc == 8'h33);
  endfunction

  // Profile positioning or continuous movement operations
  function automatic logic is_pos_move(input logic [7:0] tc);
    is_pos_move = (tc == 8'h10) || (tc == 8'h11) || (tc == 8'h20);
  endfunction

  // Supported cycle, loop, frame and mode combinations
  function automatic logic combo_ok(input frame_t f);
    combo_ok = 1'b1;
    // Full-closed loop needs the long frame for scale feedback
    if (f.full_closed && !f.frame32)
      combo_ok = 1'b0;
    // Fastest cycle only carries position mode
    if (f.cycle_sel == 2'h0 && f.ctrl_mode != MODE_POSITION)
      combo_ok = 1'b0;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Registers and internal state

  logic [7:0] limit;
  logic full_sync_en;
  logic [ST_W-1:0] status;
  logic [ST_W-1:0] mask;
  logic [ST_W-1:0] events;
  logic [7:0] tally;
  logic tally_over;
  logic tally_over_q;
  logic [1:0] prev_mode;
  logic [7:0] prev_type;
  logic have_prev;
  logic mode_change;
  logic gap_short;
  logic renew_check;
  logic cmd_check;
  logic sync_check;
  logic sync_fault;
  logic cmd_fault;
  logic homing;
  logic [ST_W-1:0] clear_bits;

  ////////////////////////////////////////////////////////////////////////
  // Check windows

  assign renew_check = rx_valid && renew_tick && link_state == LINK_ACTIVE &&
                       sync_state == SYNC_TRANSIENT;

  assign cmd_check = rx_valid && link_state == LINK_ACTIVE && sync_state == SYNC_DONE;

  assign sync_check = link_state == LINK_ACTIVE && sync_state == SYNC_TRANSIENT;

  assign sync_fault = sync_check && full_sync_en && (comm_error || comm_lost);

  ////////////////////////////////////////////////////////////////////////
  // Renewal counter tally

  renewal_tally u_tally (
    .clk(clk),
    .sys_rst(sys_rst),
    .restart(link_state == LINK_INITIAL),
    .check(renew_check),
    .renew_cnt(rx_frame.renew_cnt),
    .limit(limit),
    .tally(tally),
    .over(tally_over)
  );

  // Edge of overflow becomes the event, so it is raised once
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      tally_over_q <= 1'b0;
    else
      tally_over_q <= tally_over;
  end

  ////////////////////////////////////////////////////////////////////////
  // Control mode history

  // A change only counts once a previous frame has been seen
  assign mode_change = cmd_check && have_prev && rx_frame.ctrl_mode != prev_mode;

  // Remember last mode and subcode of evaluated frames
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      have_prev <= 1'b0;
      prev_mode <= MODE_POSITION;
      prev_type <= 8'h00;
    end
    else if (link_state == LINK_INITIAL)
      have_prev <= 1'b0;
    else if (cmd_check)
    begin
      have_prev <= 1'b1;
      prev_mode <= rx_frame.ctrl_mode;
      prev_type <= rx_frame.type_code;
    end
  end

  // two millisecond gap between mode changes
  mode_gap_timer #(
    .GAP_CYCLES(GAP_CYCLES)
  ) u_gap (
    .clk(clk),
    .sys_rst(sys_rst),
    .mode_change(mode_change),
    .too_soon(gap_short)
  );

  ////////////////////////////////////////////////////////////////////////
  // Command error decision

  assign homing = rx_frame.cyc_cmd == CMD_HOMING;

  // Combined causes; the previous subcode stands for the link_active_state operation
  always_comb
  begin
    cmd_fault = 1'b0;
    if (cmd_check)
    begin
      if (!combo_ok(rx_frame))
        cmd_fault = 1'b1;
      if (mode_change && gap_short)
        cmd_fault = 1'b1;
      // mode switch during latch or homing profile
      if (mode_change && is_latch_home(prev_type))
        cmd_fault = 1'b1;
      if (mode_change && rx_frame.busy)
        cmd_fault = 1'b1;
      // homing during latch or homing profile
      if (homing && have_prev && is_latch_home(prev_type))
        cmd_fault = 1'b1;
      // homing init during positioning or continuous move
      if (homing && have_prev && is_pos_move(prev_type) &&
          (rx_frame.type_code[7:4] == 4'h1 || rx_frame.type_code == 8'h31))
        cmd_fault = 1'b1;
      // subcode change in profile position mode
      if (have_prev && prev_mode == MODE_PROFILE && rx_frame.ctrl_mode == MODE_PROFILE &&
          rx_frame.type_code != prev_type)
        cmd_fault = 1'b1;
      // homing 1x or 2x in velocity or torque
      if (homing && (rx_frame.ctrl_mode == MODE_VELOCITY ||
          rx_frame.ctrl_mode == MODE_TORQUE) &&
          (rx_frame.type_code[7:4] == 4'h1 || rx_frame.type_code[7:4] == 4'h2))
        cmd_fault = 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Link state machine

  // sync alarm returns link to initial
  // command error leaves the link alone
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      link_state <= LINK_INITIAL;
    else
    begin
      unique case (link_state)
        LINK_INITIAL:
          if (link_up)
            link_state <= LINK_ACTIVE;
        LINK_ACTIVE:
          if (sync_fault)
            link_state <= LINK_INITIAL;
      endcase
    end
  end

  // Sync establishment; renewal alarm never disturbs it
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      sync_state <= SYNC_NONE;
    else if (link_state == LINK_INITIAL || sync_fault)
      sync_state <= SYNC_NONE;
    else
    begin
      unique case (sync_state)
        SYNC_NONE:
          if (sync_start)
            sync_state <= SYNC_TRANSIENT;
        SYNC_TRANSIENT:
          if (sync_done)
            sync_state <= SYNC_DONE;
        SYNC_DONE:
          sync_state <= SYNC_DONE;
        default:
          sync_state <= SYNC_NONE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Received data usage

  // renewal alarm still passes the frame on
  // frame carrying a command error is discarded
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      frame_accept <= 1'b0;
    else
      frame_accept <= rx_valid && link_state == LINK_ACTIVE && !cmd_fault;
  end

  ////////////////////////////////////////////////////////////////////////
  // Register writes

  // Configuration word
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      limit <= LIMIT_RESET;
      full_sync_en <= 1'b0;
    end
    else if (reg_wr && reg_addr == OFS_CONFIG)
    begin
      limit <= reg_wdata[CFG_LIMIT_LSB +: 8];
      full_sync_en <= reg_wdata[CFG_FULLSYNC_BIT];
    end
  end

  // Interrupt mask
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      mask <= '0;
    else if (reg_wr && reg_addr == OFS_MASK)
      mask <= reg_wdata[ST_W-1:0];
  end

  ////////////////////////////////////////////////////////////////////////
  // Alarm status and interrupt

  // tally alarm on crossing the limit
  assign events[ST_TALLY] = tally_over && !tally_over_q;
  assign events[ST_SYNC] = sync_fault;
  assign events[ST_CMD] = cmd_fault;

  // Tally alarm cannot be cleared by software
  always_comb
  begin
    clear_bits = '0;
    if (reg_wr && reg_addr == OFS_STATUS)
      clear_bits = reg_wdata[ST_W-1:0];
    clear_bits[ST_TALLY] = 1'b0;
  end

  // Sticky, write one to clear; a new event beats the clear
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      status <= '0;
    else
      status <= (status & ~clear_bits) | events;
  end

  // Registered alarm outputs follow the sticky bits
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      renewal_tally_alarm <= 1'b0;
      interaxis_sync_alarm <= 1'b0;
      command_error_alarm <= 1'b0;
    end
    else
    begin
      renewal_tally_alarm <= status[ST_TALLY];
      interaxis_sync_alarm <= status[ST_SYNC];
      command_error_alarm <= status[ST_CMD];
    end
  end

  assign irq = |(status & mask); // Level, unmasked alarms only

  ////////////////////////////////////////////////////////////////////////
  // Register reads

  // Data one cycle after the strobe, zero otherwise or when unmapped
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      reg_rdata <= 32'h0000_0000;
    else if (reg_rd)
    begin
      reg_rdata <= 32'h0000_0000;
      unique case (reg_addr)
        OFS_CONFIG:
        begin
          reg_rdata[CFG_LIMIT_LSB +: 8] <= limit;
          reg_rdata[CFG_FULLSYNC_BIT] <= full_sync_en;
        end
        OFS_STATUS:
          reg_rdata[ST_W-1:0] <= status;
        OFS_MASK:
          reg_rdata[ST_W-1:0] <= mask;
        OFS_STATE:
        begin
          reg_rdata[SR_LINK_BIT] <= link_state;
          reg_rdata[SR_SYNC_LSB +: 2] <= sync_state;
          reg_rdata[SR_TALLY_LSB +: 8] <= tally;
        end
        default:
          reg_rdata <= 32'h0000_0000;
      endcase
    end
    else
      reg_rdata <= 32'h0000_0000;
  end
endmodule // link_alarm_monitor

// *** verification/alarm_checker_properties.sv ***
// Port-level assertions for the link alarm monitor.
// Bound to link_alarm_monitor; single clock domain, async high reset.
`timescale 1ns/1ps
module alarm_checker
#(
  parameter int GAP_CYCLES = alarm_pkg::MODE_GAP_CYCLES
)
(
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Frame and link events
  input wire logic rx_valid,
  input wire logic renew_tick,
  input wire logic comm_error,
  input wire logic comm_lost,
  // Watched outputs
  input wire logic renewal_tally_alarm,
  input wire logic interaxis_sync_alarm,
  input wire logic command_error_alarm,
  input wire logic frame_accept,
  input wire alarm_pkg::link_state_t link_state,
  input wire alarm_pkg::sync_state_t sync_state
);
  import alarm_pkg::*;

  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);

  ////////////////////////////////////////
  // Clean frame while sync is still forming
  sequence s_clean_transient;
    rx_valid && link_state == LINK_ACTIVE && sync_state == SYNC_TRANSIENT && !comm_error
      && !comm_lost;
  endsequence

  property p_accept_cause;
    frame_accept |-> $past(rx_valid);
  endproperty
  property p_accept_transient;
    s_clean_transient |=> frame_accept;
  endproperty
  // Tally register adds one stage ahead of the status bit
  property p_tally_cause;
    $rose(renewal_tally_alarm) |-> $past(rx_valid, 3) && $past(renew_tick, 3)
      && $past(sync_state, 3) == SYNC_TRANSIENT;
  endproperty
  property p_tally_keeps;
    $rose(renewal_tally_alarm) |-> link_state == LINK_ACTIVE
      && $past(link_state) == LINK_ACTIVE && sync_state == $past(sync_state, 2);
  endproperty
  property p_sync_window;
    $rose(interaxis_sync_alarm) |-> $past(link_state, 2) == LINK_ACTIVE
      && $past(sync_state, 2) == SYNC_TRANSIENT;
  endproperty
  property p_sync_drop;
    $rose(interaxis_sync_alarm) |-> $past(link_state) == LINK_INITIAL
      && $past(sync_state) == SYNC_NONE;
  endproperty
  property p_cmd_window;
    $rose(command_error_alarm) |-> $past(rx_valid, 2) && $past(link_state, 2) == LINK_ACTIVE
      && $past(sync_state, 2) == SYNC_DONE;
  endproperty
  // Error frame is dropped but the link stays up
  property p_cmd_keeps;
    $rose(command_error_alarm) |-> link_state == LINK_ACTIVE
      && $past(link_state) == LINK_ACTIVE && !$past(frame_accept);
  endproperty

  a_accept_cause: assert property (p_accept_cause)
    else $error("frame accepted without a received frame");
  a_accept_transient: assert property (p_accept_transient)
    else $error("frame dropped during sync forming");
  a_tally_cause: assert property (p_tally_cause)
    else $error("renewal alarm outside its check window");
  a_tally_keeps: assert property (p_tally_keeps)
    else $error("renewal alarm disturbed link or sync");
  a_sync_window: assert property (p_sync_window)
    else $error("sync alarm outside transient sync");
  a_sync_drop: assert property (p_sync_drop)
    else $error("sync alarm did not drop the link");
  a_cmd_window: assert property (p_cmd_window)
    else $error("command alarm outside established sync");
  a_cmd_keeps: assert property (p_cmd_keeps)
    else $error("command alarm dropped link or kept frame");
endmodule // alarm_checker

bind link_alarm_monitor alarm_checker #(.GAP_CYCLES(GAP_CYCLES)) checker_i (.clk(clk),
  .sys_rst(sys_rst), .rx_valid(rx_valid), .renew_tick(renew_tick), .comm_error(comm_error),
  .comm_lost(comm_lost), .renewal_tally_alarm(renewal_tally_alarm),
  .interaxis_sync_alarm(interaxis_sync_alarm), .command_error_alarm(command_error_alarm),
  .frame_accept(frame_accept), .link_state(link_state), .sync_state(sync_state));

// *** verification/host_model.sv ***
// Host controller model: one decoded cyclic frame per send pulse.
// Assumes the bench pulses send for one cycle with frame fields beside it.
`timescale 1ns/1ps
module host_model
(
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Bench requests
  input wire logic send,
  input wire logic tick,
  input wire logic skip,
  input wire alarm_pkg::frame_t frame_in,
  // Frame side
  output logic rx_valid,
  output logic renew_tick,
  output alarm_pkg::frame_t rx_frame
);
  import alarm_pkg::*;

  logic [3:0] count;

  // Frame launch; idle bus toggles so stale data never looks valid
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      count <= 4'h0;
      rx_valid <= 1'b0;
      renew_tick <= 1'b0;
      rx_frame <= '0;
    end
    else
    begin
      rx_valid <= send;
      renew_tick <= send & tick;
      if (send)
      begin
        rx_frame <= frame_in;
        // successor by one, or a wrong value
        rx_frame.renew_cnt <= skip ? count + 4'h8 : count;
        if (!skip)
          count <= count + 4'h1;
      end
      else
        rx_frame <= frame_t'(~rx_frame);
    end
  end
endmodule // host_model

// *** verification/testbench.sv ***
// Self-checking bench for the link alarm monitor.
// Frames come from the host model; registers over the plain port.
`timescale 1ns/1ps
module testbench;
  import alarm_pkg::*;
  // Short mode gap keeps the run brief
  localparam int GAP = 50;
  localparam frame_t BASE = '{3'h0, MODE_POSITION, 8'h0, 4'h0, 1'b0, 1'b0, 1'b1, 2'h1};
  logic clk, sys_rst, send, tick, skip, link_up, comm_error, comm_lost, sync_start;
  logic sync_done, reg_wr, reg_rd, rx_valid, renew_tick, acc, irq, frame_accept;
  logic renewal_tally_alarm, interaxis_sync_alarm, command_error_alarm;
  logic [7:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata, rd_val;
  frame_t frame_in, rx_frame;
  link_state_t link_state;
  sync_state_t sync_state;
  int mismatches = 0, comparisons = 0, cycles = 0;

  host_model host (.clk, .sys_rst, .send, .tick, .skip, .frame_in, .rx_valid, .renew_tick,
    .rx_frame);
  link_alarm_monitor #(.GAP_CYCLES(GAP)) DUT (.clk, .sys_rst, .rx_valid, .renew_tick,
    .rx_frame, .link_up, .comm_error, .comm_lost, .sync_start, .sync_done, .reg_addr,
    .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .renewal_tally_alarm, .interaxis_sync_alarm,
    .command_error_alarm, .frame_accept, .link_state, .sync_state, .irq);

  ////////////////////////////////////////
  // Clock and hang guard
  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 6000)
    begin
      mismatches++;
      conclude();
    end
  end

  task automatic conclude();
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e)
    begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask
  // Every driver but snd ends one edge after dropping its strobe; snd ends four edges after
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd(input logic [7:0] a);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 rd_val = reg_rdata;
    @(posedge clk);
  endtask
  task automatic rst();
    sys_rst <= 1'b1;
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
  endtask
  task automatic lnk(input logic done);
    link_up <= 1'b1;
    @(posedge clk);
    link_up <= 1'b0;
    sync_start <= 1'b1;
    @(posedge clk);
    sync_start <= 1'b0;
    sync_done <= done;
    @(posedge clk);
    sync_done <= 1'b0;
    @(posedge clk);
  endtask
  task automatic snd(input frame_t f, input logic t, input logic s);
    frame_in <= f;
    tick <= t;
    skip <= s;
    send <= 1'b1;
    @(posedge clk);
    send <= 1'b0;
    @(posedge clk);
    #1 acc = frame_accept;
    repeat (3) @(posedge clk);
  endtask
  function automatic frame_t fr(input logic [2:0] c, input logic [1:0] m, input logic [7:0] t,
    input logic b = 1'b0, input logic fc = 1'b0, input logic f32 = 1'b1,
    input logic [1:0] cy = 2'h1);
    fr = '{c, m, t, 4'h0, b, fc, f32, cy};
  endfunction

  ////////////////////////////////////////
  task automatic t_regs();
    logic [7:0] ofs [5] = '{OFS_CONFIG, OFS_STATUS, OFS_MASK, OFS_STATE, 8'h20};
    wr(8'h20, 32'hffffffff);
    foreach (ofs[i])
    begin
      rd(ofs[i]);
      chk("reset value", 32'h0, rd_val);
    end
    $display("t_regs done");
  endtask
  task automatic t_limit_off();
    for (int lim = 0; lim < 2; lim++)
    begin
      rst();
      wr(OFS_CONFIG, 32'(lim));
      lnk(1'b0);
      // Error without full-sync must leave the link alone
      comm_error <= 1'b1;
      @(posedge clk);
      comm_error <= 1'b0;
      snd(BASE, 1'b1, 1'b0);
      repeat (4) snd(BASE, 1'b1, 1'b1);
      chk("sync alarm off", 32'h0, interaxis_sync_alarm);
      chk("tally alarm off", 32'h0, renewal_tally_alarm);
      rd(OFS_STATE);
      chk("state", 32'h0403, rd_val);
    end
    $display("t_limit_off done");
  endtask
  task automatic t_tally();
    rst();
    wr(OFS_CONFIG, 32'h2);
    wr(OFS_MASK, 32'h1);
    lnk(1'b0);
    snd(BASE, 1'b1, 1'b0);
    snd(BASE, 1'b0, 1'b1);
    repeat (2) snd(BASE, 1'b1, 1'b1);
    chk("tally alarm early", 32'h0, renewal_tally_alarm);
    chk("irq early", 32'h0, irq);
    snd(BASE, 1'b1, 1'b1);
    chk("accept", 32'h1, acc);
    chk("tally alarm", 32'h1, renewal_tally_alarm);
    chk("irq", 32'h1, irq);
    rd(OFS_STATE);
    chk("state", 32'h0303, rd_val);
    $display("t_tally done");
  endtask
  task automatic t_sync();
    rst();
    wr(OFS_CONFIG, 32'h100);
    lnk(1'b0);
    comm_error <= 1'b1;
    @(posedge clk);
    comm_error <= 1'b0;
    repeat (2) @(posedge clk);
    chk("sync alarm", 32'h1, interaxis_sync_alarm);
    chk("link", LINK_INITIAL, link_state);
    chk("sync", SYNC_NONE, sync_state);
    chk("irq masked", 32'h0, irq);
    wr(OFS_MASK, 32'h2);
    chk("irq", 32'h1, irq);
    wr(OFS_STATUS, 32'h2);
    @(posedge clk);
    chk("sync alarm cleared", 32'h0, interaxis_sync_alarm);
    chk("irq cleared", 32'h0, irq);
    // Interruption while forming also drops the link
    lnk(1'b0);
    comm_lost <= 1'b1;
    @(posedge clk);
    comm_lost <= 1'b0;
    repeat (2) @(posedge clk);
    chk("sync alarm lost", 32'h1, interaxis_sync_alarm);
    chk("link lost", LINK_INITIAL, link_state);
    wr(OFS_STATUS, 32'h2);
    lnk(1'b1);
    comm_lost <= 1'b1;
    @(posedge clk);
    comm_lost <= 1'b0;
    repeat (3) @(posedge clk);
    chk("sync alarm done", 32'h0, interaxis_sync_alarm);
    $display("t_sync done");
  endtask
  // Quiet start, legal first frame, then the offending one
  task automatic cs(input frame_t a, input frame_t b, input logic soon);
    repeat (2) snd(BASE, 1'b0, 1'b0);
    wr(OFS_STATUS, 32'h4);
    repeat (GAP) @(posedge clk);
    snd(a, 1'b0, 1'b0);
    chk("first frame alarm", 32'h0, command_error_alarm);
    if (!soon)
      repeat (GAP) @(posedge clk);
    snd(b, 1'b0, 1'b0);
    chk("command alarm", 32'h1, command_error_alarm);
    chk("accept", 32'h0, acc);
    chk("link", LINK_ACTIVE, link_state);
  endtask
  task automatic t_cmd();
    rst();
    lnk(1'b1);
    cs(BASE, fr(3'h0, MODE_POSITION, 8'h0, 1'b0, 1'b1, 1'b0), 1'b0);
    cs(BASE, fr(3'h0, MODE_VELOCITY, 8'h0, 1'b0, 1'b0, 1'b1, 2'h0), 1'b0);
    cs(fr(3'h0, MODE_VELOCITY, 8'h0), fr(3'h0, MODE_TORQUE, 8'h0), 1'b1);
    cs(fr(3'h0, MODE_POSITION, 8'h12), fr(3'h0, MODE_VELOCITY, 8'h0), 1'b0);
    cs(BASE, fr(3'h0, MODE_VELOCITY, 8'h0, 1'b1), 1'b0);
    cs(fr(3'h0, MODE_POSITION, 8'h31), fr(CMD_HOMING, MODE_POSITION, 8'h31), 1'b0);
    cs(fr(3'h0, MODE_POSITION, 8'h10), fr(CMD_HOMING, MODE_POSITION, 8'h31), 1'b0);
    cs(fr(3'h0, MODE_PROFILE, 8'h10), fr(3'h0, MODE_PROFILE, 8'h11), 1'b0);
    cs(fr(3'h0, MODE_VELOCITY, 8'h0), fr(CMD_HOMING, MODE_VELOCITY, 8'h20), 1'b0);
    cs(fr(3'h0, MODE_TORQUE, 8'h0), fr(CMD_HOMING, MODE_TORQUE, 8'h10), 1'b0);
    $display("t_cmd done");
  endtask

  ////////////////////////////////////////
  // Main sequence
  initial
  begin
    sys_rst = 1'b1;
    {send, tick, skip, link_up, comm_error, comm_lost, sync_start, sync_done} = '0;
    {reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
    frame_in = '0;
    repeat (6) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    t_regs();
    t_limit_off();
    t_tally();
    t_sync();
    t_cmd();
    conclude();
  end
endmodule // testbench
